// *** rtl/fabric_access_pkg.sv ***
// Shared constants for the indirect register read path and flow control resolver
package fabric_access_pkg;
	localparam int NUM_PORTS = 3;
	localparam int IDX_W     = 16;
	// Indirect command word layout
	localparam int BIT_PENDING   = 31;
	localparam int BIT_READ      = 30;
	localparam int BIT_STEP_UP   = 29;
	localparam int BIT_STEP_DOWN = 28;
	localparam int IDX_LSB       = 0;
	// Host-side AXI4-Lite register offsets
	localparam logic [3:0] OFF_CMD    = 4'h0;
	localparam logic [3:0] OFF_DATA   = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Cycles the fabric needs to fetch one register
	localparam logic [3:0] FETCH_CYCLES = 4'h4;
	localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_DONE  = 2'b11
	} fetch_state_t;

	// Per-port flow control inputs
	typedef struct packed {
		logic full_duplex;
		logic an_enable;
		logic an_complete;
		logic partner_an_able;
		logic override_select;
		logic backpressure_enable;
		logic manual_tx_pause;
		logic manual_rx_pause;
		logic local_pause;
		logic local_asym;
		logic partner_pause;
		logic partner_asym;
	} port_flow_t;
endpackage

// *** rtl/fabric_access_if.sv ***
// Interface joining the host controller and the indirect access device
`timescale 1ns/1ps
interface fabric_access_if;
	logic        cmd_wr;
	logic [31:0] cmd_wdata;
	logic        data_rd;
	logic [31:0] cmd_rdata;
	logic [31:0] data_rdata;

	modport device (
		input  cmd_wr,
		input  cmd_wdata,
		input  data_rd,
		output cmd_rdata,
		output data_rdata
	);
	modport host (
		output cmd_wr,
		output cmd_wdata,
		output data_rd,
		input  cmd_rdata,
		input  data_rdata
	);
endinterface

// *** rtl/flow_enable_resolve.sv ***
// Per-port flow control enable resolver
`timescale 1ns/1ps
module flow_enable_resolve (
	input  wire logic                          clk_sys,
	input  wire logic                          resetn,
	input  wire fabric_access_pkg::port_flow_t cfg,
	output logic                               rx_enable,
	output logic                               tx_enable
);
	logic next_rx;
	logic next_tx;

	always_comb begin
		next_rx = 1'b0;
		next_tx = 1'b0;
		if (!cfg.full_duplex) begin
			// Half duplex ignores negotiation state entirely
			next_tx = cfg.backpressure_enable;
		end else if (cfg.override_select || !cfg.an_enable) begin
			next_rx = cfg.manual_rx_pause;
			next_tx = cfg.manual_tx_pause;
		end else if (!cfg.an_complete || !cfg.partner_an_able) begin
			// Still negotiating, or a partner unable to negotiate: both enables stay at zero
			next_rx = 1'b0;
			next_tx = 1'b0;
		end else if (cfg.local_pause && cfg.partner_pause) begin
			next_rx = 1'b1;
			next_tx = 1'b1;
		end else if (!cfg.local_pause && cfg.local_asym && cfg.partner_pause
				&& cfg.partner_asym) begin
			next_tx = 1'b1;
		end else if (cfg.local_pause && cfg.local_asym && !cfg.partner_pause
				&& cfg.partner_asym) begin
			next_rx = 1'b1;
		end
		// Remaining negotiated combinations keep both at zero
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_enable <= 1'b0;
			tx_enable <= 1'b0;
		end else begin
			rx_enable <= next_rx;
			tx_enable <= next_tx;
		end
	end
endmodule

// *** rtl/fabric_access_device.sv ***
// Device end: indirect register read engine and per-port flow control enables
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module fabric_access_device (
	input  wire logic                           clk_sys,
	input  wire logic                           resetn,
	fabric_access_if.device                     bus,
	// Fabric register space fetch port
	output logic                                fetch_req,
	output logic [fabric_access_pkg::IDX_W-1:0] fetch_index,
	input  wire logic [31:0]                    fetch_data,
	// Per-port link and manual flow settings; port 0 is the virtual port
	input  wire fabric_access_pkg::port_flow_t  port_cfg [fabric_access_pkg::NUM_PORTS],
	output logic [fabric_access_pkg::NUM_PORTS-1:0] rx_flow_enable,
	output logic [fabric_access_pkg::NUM_PORTS-1:0] tx_flow_enable
);
	fabric_access_pkg::fetch_state_t state;
	logic                            pending;
	logic                            step_up;
	logic                            step_down;
	logic                            read_not_write;
	logic [fabric_access_pkg::IDX_W-1:0] target_index;
	logic [31:0]                     indirect_data_reg;
	logic [3:0]                      wait_count;
	logic                            start_cmd;
	logic                            start_step;
	logic                            cmd_accept;
	logic                            fetch_last;
	logic                            launch;

	//////////////////////////////////////////////////////////////////////////
	// Command decode

	// Writes while a fetch runs are dropped so the running index stays stable
	assign cmd_accept = bus.cmd_wr && !pending;
	assign start_cmd  = cmd_accept && bus.cmd_wdata[fabric_access_pkg::BIT_PENDING]
		&& bus.cmd_wdata[fabric_access_pkg::BIT_READ];
	assign start_step = bus.data_rd && !pending && (step_up || step_down);
	// A new fetch may only begin from idle
	assign launch     = (state == fabric_access_pkg::ST_IDLE) && (start_cmd || start_step);
	// Last fetch cycle: the fabric word is valid and gets captured
	assign fetch_last = (state == fabric_access_pkg::ST_FETCH) && (wait_count == 4'h1);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			step_up   <= 1'b0;
			step_down <= 1'b0;
		end else if (cmd_accept) begin
			// Clearing step bits here is how the host stops the last refetch
			step_up   <= bus.cmd_wdata[fabric_access_pkg::BIT_STEP_UP];
			step_down <= bus.cmd_wdata[fabric_access_pkg::BIT_STEP_DOWN];
		end
	end

	// Direction is only stored; write cycles are not carried out here
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			read_not_write <= 1'b0;
		end else if (cmd_accept) begin
			read_not_write <= bus.cmd_wdata[fabric_access_pkg::BIT_READ];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			target_index <= '0;
		end else if (cmd_accept) begin
			target_index <= bus.cmd_wdata[fabric_access_pkg::IDX_LSB +: fabric_access_pkg::IDX_W];
		end else if (start_step) begin
			// Step up wins if software sets both
			target_index <= step_up ? target_index + 16'h0001
				: target_index - 16'h0001;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Fetch sequencer

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= fabric_access_pkg::ST_IDLE;
		end else begin
			unique case (state)
				fabric_access_pkg::ST_IDLE: begin
					if (start_cmd || start_step) begin
						state <= fabric_access_pkg::ST_FETCH;
					end
				end
				fabric_access_pkg::ST_FETCH: begin
					if (wait_count == 4'h1) begin
						state <= fabric_access_pkg::ST_DONE;
					end
				end
				fabric_access_pkg::ST_DONE: begin
					// Data register was loaded on the previous edge
					state <= fabric_access_pkg::ST_IDLE;
				end
				default: begin
					// The one unused code recovers to idle
					state <= fabric_access_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Pending stays up one cycle past the capture so the data word has settled
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pending <= 1'b0;
		end else if (launch) begin
			pending <= 1'b1;
		end else if (state != fabric_access_pkg::ST_IDLE
				&& state != fabric_access_pkg::ST_FETCH) begin
			pending <= 1'b0;
		end
	end

	// Counter is only meaningful in the fetch state
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wait_count <= 4'h0;
		end else if (launch) begin
			wait_count <= fabric_access_pkg::FETCH_CYCLES;
		end else if (state == fabric_access_pkg::ST_FETCH) begin
			wait_count <= wait_count - 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			indirect_data_reg <= fabric_access_pkg::WORD_ZERO;
		end else if (fetch_last) begin
			indirect_data_reg <= fetch_data;
		end
	end

	// The fabric sees a steady index for the whole request
	assign fetch_req   = (state == fabric_access_pkg::ST_FETCH);
	assign fetch_index = target_index;

	// Command read-back; unused bits read as zero
	always_comb begin
		bus.cmd_rdata = fabric_access_pkg::WORD_ZERO;
		bus.cmd_rdata[fabric_access_pkg::BIT_PENDING]   = pending;
		bus.cmd_rdata[fabric_access_pkg::BIT_READ]      = read_not_write;
		bus.cmd_rdata[fabric_access_pkg::BIT_STEP_UP]   = step_up;
		bus.cmd_rdata[fabric_access_pkg::BIT_STEP_DOWN] = step_down;
		bus.cmd_rdata[fabric_access_pkg::IDX_LSB +: fabric_access_pkg::IDX_W] = target_index;
	end
	assign bus.data_rdata = indirect_data_reg;

	//////////////////////////////////////////////////////////////////////////
	// Flow control enables

	// Resolver reads copies only; advertisement sources are never written
	genvar p;
	generate
		for (p = 0; p < fabric_access_pkg::NUM_PORTS; p++) begin : g_port
			fabric_access_pkg::port_flow_t eff;
			always_comb begin
				eff = port_cfg[p];
				if (p == 0) begin
					// Virtual port registers are seen from the far side
					eff.local_pause   = port_cfg[p].partner_pause;
					eff.local_asym    = port_cfg[p].partner_asym;
					eff.partner_pause = port_cfg[p].local_pause;
					eff.partner_asym  = port_cfg[p].local_asym;
				end
			end
			flow_enable_resolve u_resolve (
				.clk_sys   (clk_sys),
				.resetn    (resetn),
				.cfg       (eff),
				.rx_enable (rx_flow_enable[p]),
				.tx_enable (tx_flow_enable[p])
			);
		end
	endgenerate
endmodule

// *** rtl/fabric_access_host.sv ***
// Host end: AXI4-Lite slave that forwards software accesses to the device end
`timescale 1ns/1ps
module fabric_access_host (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	fabric_access_if.host    link,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	logic        aw_held;
	logic        w_held;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic        do_write;
	logic        do_read;

	//////////////////////////////////////////////////////////////////////////
	// Write channel

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			w_held <= 1'b0;
			w_data <= fabric_access_pkg::WORD_ZERO;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// Only the command word is writable; byte strobes are not honoured
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= fabric_access_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == fabric_access_pkg::OFF_CMD)
				? fabric_access_pkg::RESP_OKAY : fabric_access_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign link.cmd_wr    = do_write && (aw_addr == fabric_access_pkg::OFF_CMD);
	assign link.cmd_wdata = w_data;

	//////////////////////////////////////////////////////////////////////////
	// Read channel

	assign s_axi_arready = !s_axi_rvalid;
	assign do_read       = s_axi_arvalid && s_axi_arready;
	// The data read itself is what advances a step sequence
	assign link.data_rd  = do_read && (s_axi_araddr == fabric_access_pkg::OFF_DATA);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= fabric_access_pkg::WORD_ZERO;
			s_axi_rresp  <= fabric_access_pkg::RESP_OKAY;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= fabric_access_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				fabric_access_pkg::OFF_CMD:    s_axi_rdata <= link.cmd_rdata;
				fabric_access_pkg::OFF_DATA:   s_axi_rdata <= link.data_rdata;
				fabric_access_pkg::OFF_STATUS: begin
					s_axi_rdata <= {31'h0000_0000,
						link.cmd_rdata[fabric_access_pkg::BIT_PENDING]};
				end
				default: begin
					s_axi_rdata <= fabric_access_pkg::WORD_ZERO;
					s_axi_rresp <= fabric_access_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// *** dv/fabric_access_monitor.sv ***
// Assertions on the link between the host end and the device end
`timescale 1ns/1ps
module fabric_access_monitor (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        cmd_wr,
	input wire logic [31:0] cmd_wdata,
	input wire logic        data_rd,
	input wire logic [31:0] cmd_rdata,
	input wire logic [31:0] data_rdata
);
	logic pend;
	logic solo;
	assign pend = cmd_rdata[31];
	// Data read alone, no fetch under way
	assign solo = data_rd && !cmd_wr && !pend;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	//////////////////////////////////////////////////////////////////////////////
	start_fetch_a: assert property (cmd_wr && cmd_wdata[31] && cmd_wdata[30] && !pend |=> pend)
		else $error("read command did not start a fetch");
	busy_len_a: assert property ($rose(pend) |-> pend[*5] ##1 !pend)
		else $error("pending flag length wrong");
	data_hold_a: assert property (!pend ##1 !pend |-> $stable(data_rdata))
		else $error("data register moved while idle");
	busy_ignore_a: assert property (cmd_wr && pend |=> $stable(cmd_rdata[30:0]))
		else $error("command taken while pending");
	step_up_a: assert property (solo && cmd_rdata[29] |=>
		pend && cmd_rdata[15:0] == $past(cmd_rdata[15:0]) + 16'h0001)
		else $error("step up failed");
	step_down_a: assert property (solo && cmd_rdata[29:28] == 2'b01 |=>
		pend && cmd_rdata[15:0] == $past(cmd_rdata[15:0]) - 16'h0001)
		else $error("step down failed");
	no_step_a: assert property (solo && cmd_rdata[29:28] == 2'b00 |=> !pend)
		else $error("extra fetch without step");
	cover property (solo && cmd_rdata[29]);
	cover property (solo && cmd_rdata[28]);
	cover property (cmd_wr && pend);
endmodule

// *** dv/switch_csr_read_and_fc_enable_tb.sv ***
// Bench for the indirect read path and the flow control enables
`timescale 1ns/1ps
module switch_csr_read_and_fc_enable_tb;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, fetch_data = 32'h0, d, rdata;
	logic        awready, wready, bvalid, arready, rvalid, fetch_req;
	logic [1:0]  bresp, rresp, r, e0, e2;
	logic [15:0] fetch_index, ix, s;
	logic [11:0] x;
	logic [2:0]  rxe, txe;
	int          n_fail = 0, n_checks = 0, cyc = 0;
	fabric_access_pkg::port_flow_t port_cfg [fabric_access_pkg::NUM_PORTS];
	fabric_access_if link_if ();
	fabric_access_host fabric_access_host_i (.clk_sys(clk_sys), .resetn(resetn), .link(link_if),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	fabric_access_device fabric_access_device_i (.clk_sys(clk_sys), .resetn(resetn),
		.bus(link_if), .fetch_req(fetch_req), .fetch_index(fetch_index),
		.fetch_data(fetch_data), .port_cfg(port_cfg), .rx_flow_enable(rxe),
		.tx_flow_enable(txe));
	fabric_access_monitor fabric_access_monitor_i (.clk_sys(clk_sys), .resetn(resetn),
		.cmd_wr(link_if.cmd_wr), .cmd_wdata(link_if.cmd_wdata), .data_rd(link_if.data_rd),
		.cmd_rdata(link_if.cmd_rdata), .data_rdata(link_if.data_rdata));
	//////////////////////////////////////////////////////////////////////////////
	always #12.5 clk_sys = ~clk_sys;
	// Fabric answers with its index; outside a fetch the word keeps toggling
	always @(posedge clk_sys) fetch_data <= fetch_req ? {16'hc35a, fetch_index} : ~fetch_data;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			end_sim();
		end
	end
	task end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task poll();
		d = 32'h1;
		for (int i = 0; i < 20 && d[0] !== 1'b0; i++) rd(fabric_access_pkg::OFF_STATUS);
		chk("pending", 32'h0, {31'h0, d[0]});
	endtask
	function logic [31:0] cw(logic p, logic u, logic dn, logic [15:0] i);
		return {p, 1'b1, u, dn, 12'h000, i};
	endfunction
	// Expected {rx, tx}
	function logic [1:0] fr(logic [11:0] v);
		if (!v[11]) return {1'b0, v[6]};
		if (v[7] || !v[10]) return {v[4], v[5]};
		if (!v[9] || !v[8]) return 2'b00;
		if (v[3] && v[1]) return 2'b11;
		if (!v[3] && v[2] && v[1] && v[0]) return 2'b01;
		if (v[3] && v[2] && !v[1] && v[0]) return 2'b10;
		return 2'b00;
	endfunction
	initial begin
		foreach (port_cfg[p]) port_cfg[p] = '0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(fabric_access_pkg::OFF_CMD);
		chk("cmd reset", 32'h0, d);
		rd(4'hc);
		chk("unmapped data", 32'h0, d);
		chk("unmapped resp", {30'h0, fabric_access_pkg::RESP_SLVERR}, {30'h0, r});
		wr(fabric_access_pkg::OFF_DATA, 32'h1);
		chk("data write resp", {30'h0, fabric_access_pkg::RESP_SLVERR}, {30'h0, r});
		wr(fabric_access_pkg::OFF_CMD, cw(1'b1, 1'b0, 1'b0, 16'h1234));
		chk("cmd write resp", {30'h0, fabric_access_pkg::RESP_OKAY}, {30'h0, r});
		poll();
		rd(fabric_access_pkg::OFF_DATA);
		chk("single data", 32'hc35a_1234, d);
		poll();
		$display("test single done");
		for (int k = 0; k < 2; k++) begin
			ix = k ? 16'h0001 : 16'hfffe;
			s = k ? 16'hffff : 16'h0001;
			wr(fabric_access_pkg::OFF_CMD, cw(1'b1, k == 0, k == 1, ix));
			for (int j = 0; j < 3; j++) begin
				poll();
				if (j == 2) wr(fabric_access_pkg::OFF_CMD, cw(1'b0, 1'b0, 1'b0, ix));
				rd(fabric_access_pkg::OFF_DATA);
				chk("step data", {16'hc35a, ix}, d);
				ix = ix + s;
			end
			poll();
			rd(fabric_access_pkg::OFF_CMD);
			chk("step cmd", cw(1'b0, 1'b0, 1'b0, ix - s), d);
		end
		$display("test step done");
		wr(fabric_access_pkg::OFF_CMD, cw(1'b1, 1'b0, 1'b0, 16'h0010));
		wr(fabric_access_pkg::OFF_CMD, cw(1'b1, 1'b0, 1'b0, 16'h0020));
		poll();
		rd(fabric_access_pkg::OFF_DATA);
		chk("busy data", 32'hc35a_0010, d);
		$display("test busy done");
		for (int v = 0; v < 4096; v++) begin
			x = v[11:0];
			e0 = fr(x);
			e2 = fr(~x);
			@(posedge clk_sys);
			port_cfg[0] <= {x[11:4], x[1:0], x[3:2]};
			port_cfg[1] <= x;
			port_cfg[2] <= ~x;
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk("rx enables", {29'h0, e2[1], e0[1], e0[1]}, {29'h0, rxe});
			chk("tx enables", {29'h0, e2[0], e0[0], e0[0]}, {29'h0, txe});
		end
		@(posedge clk_sys);
		resetn <= 1'b0;
		@(negedge clk_sys);
		chk("enables in reset", 32'h0, {26'h0, rxe, txe});
		@(posedge clk_sys);
		resetn <= 1'b1;
		$display("test flow done");
		end_sim();
	end
endmodule
